// [inc/pbc_pkg.sv]
package pbc_pkg;

    // Port count and selector widths.
    localparam int NUM_PORTS = 2;
    localparam int PORT_W    = 4;
    localparam int PAGE_W    = 3;
    localparam logic [PAGE_W-1:0] PORT_PAGE = 3'h0;

    // Register byte offsets on the bus.
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR     = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PORT_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_PORT_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_PHY_STAT  = 8'h18;

    // Control register fields.
    localparam int CTRL_SRR      = 0;
    localparam int CTRL_WDOG     = 1;
    localparam int CTRL_ACCEL    = 2;
    localparam int CTRL_MULTI    = 3;
    localparam int CTRL_PAGE_LSB = 4;
    localparam int CTRL_PORT_LSB = 8;

    // Event flag bits, shared by status, clear and enable registers.
    localparam int EV_LOOP = 0;
    localparam int EV_PWR  = 1;
    localparam int EV_TMO  = 2;
    localparam int EV_PORT = 3;
    localparam int EV_W    = 4;

    // Port control and port status fields.
    localparam int PC_INTEN = 0;
    localparam int PC_DIS   = 1;
    localparam int PS_CON   = 0;
    localparam int PS_BIAS  = 1;
    localparam int PS_FAULT = 2;
    localparam int PS_DIS   = 3;
    localparam int PS_INTEN = 4;

    // PHY status fields.
    localparam int PH_LINK  = 0;
    localparam int PH_CSS   = 1;
    localparam int PH_BUSY  = 2;
    localparam int PH_SHORT = 3;

    // Bus reset timing.
    localparam int CLK_MHZ         = 50;
    localparam int SHORT_RESET_NS  = 1300;
    localparam int SHORT_RESET_CYC = (SHORT_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int LONG_RESET_US   = 166;
    localparam int LONG_RESET_CYC  = LONG_RESET_US * CLK_MHZ;
    localparam int RST_CNT_W       = 14;

    // Bus reset sequencer states.
    typedef enum logic [1:0] {
        RST_IDLE,
        RST_SHORT,
        RST_LONG
    } pbc_rst_state_t;

endpackage : pbc_pkg

// [hw/pbc_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module pbc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } pbc_sync_state_t;

    pbc_sync_state_t s_reg;
    pbc_sync_state_t s_next;

    // The first stage feeds only the second stage.
    always_comb begin
        s_next      = s_reg;
        s_next.meta = d;
        s_next.sync = s_reg.meta;
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.sync;

endmodule : pbc_sync

`default_nettype wire

// [hw/pbc_port_evt.sv]
`timescale 1ns/10ps
`default_nettype none

module pbc_port_evt
    import pbc_pkg::*;
(
    // Clock and reset.
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // Per-port status, control and resume starts.
    input  wire logic [NUM_PORTS-1:0] bias,
    input  wire logic [NUM_PORTS-1:0] con,
    input  wire logic [NUM_PORTS-1:0] fault,
    input  wire logic [NUM_PORTS-1:0] dis,
    input  wire logic [NUM_PORTS-1:0] int_en,
    input  wire logic [NUM_PORTS-1:0] resume_start,
    input  wire logic                 wdog,
    // One-cycle pulse when any port raises an event.
    output logic                      port_event
);

    typedef struct packed {
        logic [NUM_PORTS-1:0] bias;
        logic [NUM_PORTS-1:0] con;
        logic [NUM_PORTS-1:0] fault;
        logic [NUM_PORTS-1:0] dis;
    } pbc_port_state_t;

    pbc_port_state_t      s_reg;
    pbc_port_state_t      s_next;
    logic [NUM_PORTS-1:0] evt;

    // Each port compares its status to the last cycle's copy.
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        assign evt[i] = (int_en[i] & (((bias[i] ^ s_reg.bias[i]) & ~dis[i])
                                      | (con[i] ^ s_reg.con[i])
                                      | (dis[i] ^ s_reg.dis[i])
                                      | (fault[i] ^ s_reg.fault[i])))
                        | (wdog & resume_start[i]);
    end

    // Remember the current status.
    always_comb begin
        s_next       = s_reg;
        s_next.bias  = bias;
        s_next.con   = con;
        s_next.fault = fault;
        s_next.dis   = dis;
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign port_event = |evt;

endmodule : pbc_port_evt

`default_nettype wire

// [hw/pbc_top.sv]
// What this block does
// - Short reset request starts 1.3 us reset; bus reset clears it.
// - Short reset may become long with legacy nodes.
// - Arbitration timeout at tree start sets loop flag.
// - Loop and watchdog wake inactive link controller.
// - Only loop nodes see config timeout; others state-timeout.
// - Cable supply falling edge sets power-fail flag.
// - State timeout sets flag and performs bus reset.
// - Enabled port status change sets port change flag.
// - Watchdog lets resume start set port change flag.
// - Acceleration enable; hardware reset only clears it.
// - Multispeed enable; hardware reset only clears it.
// - Three-bit page index, hardware reset clears it.
// - Four-bit port index, hardware reset clears it.
// - Enabled port event sets flag and notifies link.
// - Unimplemented port reads zero in port page.
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module pbc_top
    import pbc_pkg::*;
#(
    parameter int LONG_CYC = LONG_RESET_CYC
) (
    // Clock and reset.
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave.
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    // Pins from the cable side and the link controller.
    input  wire logic                 cable_supply_sense,
    input  wire logic                 link_active,
    input  wire logic [NUM_PORTS-1:0] port_bias,
    input  wire logic [NUM_PORTS-1:0] port_con,
    input  wire logic [NUM_PORTS-1:0] port_fault,
    // Same-clock pulses from the PHY core.
    input  wire logic                 arb_opportunity,
    input  wire logic                 tree_id_timeout,
    input  wire logic                 state_timeout,
    input  wire logic                 bus_reset_seen,
    input  wire logic [NUM_PORTS-1:0] resume_start,
    // Controls to the PHY core and the link.
    output logic                      bus_reset_drive,
    output logic                      bus_reset_short,
    output logic                      accel_en,
    output logic                      multi_en,
    output logic [PAGE_W-1:0]         page_sel,
    output logic [PORT_W-1:0]         port_sel,
    output logic [NUM_PORTS-1:0]      port_dis,
    output logic                      link_wake,
    output logic                      irq
);

    typedef struct packed {
        logic                 wr_pend;
        logic [ADDR_W-1:0]    wr_addr;
        logic [31:0]          rdata;
        logic                 srr;
        logic                 wdog;
        logic                 accel;
        logic                 multi;
        logic [PAGE_W-1:0]    page;
        logic [PORT_W-1:0]    port;
        logic [EV_W-1:0]      ev;
        logic [EV_W-1:0]      ev_en;
        logic [NUM_PORTS-1:0] int_en;
        logic [NUM_PORTS-1:0] dis;
        logic                 css_prev;
        pbc_rst_state_t       rst;
        logic [RST_CNT_W-1:0] cnt;
        logic                 irq;
        logic                 wake;
    } pbc_top_state_t;

    localparam int SYNC_W = 2 + 3 * NUM_PORTS;

    pbc_top_state_t       s_reg;
    pbc_top_state_t       s_next;
    logic [SYNC_W-1:0]    sync_q;
    logic                 css_s;
    logic                 link_s;
    logic [NUM_PORTS-1:0] bias_s;
    logic [NUM_PORTS-1:0] con_s;
    logic [NUM_PORTS-1:0] fault_s;
    logic                 port_event;

    // All pin inputs pass two flip-flops before any logic reads them.
    pbc_sync #(
        .W (SYNC_W)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({port_fault, port_con, port_bias, link_active, cable_supply_sense}),
        .q       (sync_q)
    );

    assign css_s   = sync_q[0];
    assign link_s  = sync_q[1];
    assign bias_s  = sync_q[2 +: NUM_PORTS];
    assign con_s   = sync_q[2 + NUM_PORTS +: NUM_PORTS];
    assign fault_s = sync_q[2 + 2 * NUM_PORTS +: NUM_PORTS];

    // Per-port change detection.
    pbc_port_evt u_port_evt (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .bias         (bias_s),
        .con          (con_s),
        .fault        (fault_s),
        .dis          (s_reg.dis),
        .int_en       (s_reg.int_en),
        .resume_start (resume_start),
        .wdog         (s_reg.wdog),
        .port_event   (port_event)
    );

    // Bus logic, event flags, reset sequencer and read data.
    always_comb begin
        logic            addr_ok;
        logic            wr_now;
        logic            psel_ok;
        logic            bus_reset;
        logic [EV_W-1:0] ev_set;
        logic [EV_W-1:0] ev_clr;
        logic [31:0]     rd;
        addr_ok   = 1'b0;
        wr_now    = 1'b0;
        psel_ok   = 1'b0;
        bus_reset = 1'b0;
        ev_set    = '0;
        ev_clr    = '0;
        rd        = '0;
        s_next    = s_reg;

        // Address phase capture; every transfer is zero-wait.
        addr_ok        = hsel & hready & htrans[1];
        s_next.wr_pend = addr_ok & hwrite;
        if (addr_ok) begin
            s_next.wr_addr = haddr[ADDR_W-1:0];
        end
        wr_now = s_reg.wr_pend;

        // Data phase writes.
        if (wr_now) begin
            case (s_reg.wr_addr)
                ADDR_CTRL: begin
                    s_next.srr   = s_reg.srr | hwdata[CTRL_SRR];
                    s_next.wdog  = hwdata[CTRL_WDOG];
                    s_next.accel = hwdata[CTRL_ACCEL];
                    s_next.multi = hwdata[CTRL_MULTI];
                    s_next.page  = hwdata[CTRL_PAGE_LSB +: PAGE_W];
                    s_next.port  = hwdata[CTRL_PORT_LSB +: PORT_W];
                end
                ADDR_CLEAR: begin
                    ev_clr = hwdata[EV_W-1:0];
                end
                ADDR_IRQ_EN: begin
                    s_next.ev_en = hwdata[EV_W-1:0];
                end
                ADDR_PORT_CTRL: begin
                    for (int i = 0; i < NUM_PORTS; i++) begin
                        if (s_reg.page == PORT_PAGE && s_reg.port == PORT_W'(i)) begin
                            s_next.int_en[i] = hwdata[PC_INTEN];
                            s_next.dis[i]    = hwdata[PC_DIS];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Event sources.
        s_next.css_prev = css_s;
        ev_set[EV_LOOP] = tree_id_timeout;
        ev_set[EV_PWR]  = s_reg.css_prev & ~css_s;
        ev_set[EV_TMO]  = state_timeout;
        ev_set[EV_PORT] = port_event;
        s_next.ev       = (s_reg.ev & ~ev_clr) | ev_set;

        // Bus reset sequencer; a state timeout takes priority.
        case (s_reg.rst)
            RST_IDLE: begin
                if (state_timeout) begin
                    s_next.rst = RST_LONG;
                    s_next.cnt = RST_CNT_W'(LONG_CYC - 1);
                    bus_reset  = 1'b1;
                end else if (s_reg.srr && arb_opportunity) begin
                    s_next.rst = RST_SHORT;
                    s_next.cnt = RST_CNT_W'(SHORT_RESET_CYC - 1);
                    bus_reset  = 1'b1;
                end
            end
            RST_SHORT, RST_LONG: begin
                if (s_reg.cnt == '0) begin
                    s_next.rst = RST_IDLE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            default: begin
                s_next.rst = RST_IDLE;
            end
        endcase

        // A reset from elsewhere, even a long one replacing ours, also counts.
        if (bus_reset || bus_reset_seen) begin
            s_next.srr = 1'b0;
        end

        // Interrupt and link wake-up, both registered.
        s_next.irq  = |(s_next.ev & s_next.ev_en);
        s_next.wake = s_next.ev[EV_LOOP] & s_next.wdog & ~link_s;

        // Read data reflects any write landing in the same cycle.
        psel_ok = (s_next.page == PORT_PAGE) && (s_next.port < PORT_W'(NUM_PORTS));
        if (addr_ok && !hwrite) begin
            case (haddr[ADDR_W-1:0])
                ADDR_CTRL: begin
                    rd[CTRL_SRR]                  = s_next.srr;
                    rd[CTRL_WDOG]                 = s_next.wdog;
                    rd[CTRL_ACCEL]                = s_next.accel;
                    rd[CTRL_MULTI]                = s_next.multi;
                    rd[CTRL_PAGE_LSB +: PAGE_W]   = s_next.page;
                    rd[CTRL_PORT_LSB +: PORT_W]   = s_next.port;
                end
                ADDR_STATUS: begin
                    rd[EV_W-1:0] = s_next.ev;
                end
                ADDR_IRQ_EN: begin
                    rd[EV_W-1:0] = s_next.ev_en;
                end
                ADDR_PORT_CTRL, ADDR_PORT_STAT: begin
                    for (int i = 0; i < NUM_PORTS; i++) begin
                        if (psel_ok && s_next.port == PORT_W'(i)) begin
                            if (haddr[ADDR_W-1:0] == ADDR_PORT_CTRL) begin
                                rd[PC_INTEN] = s_next.int_en[i];
                                rd[PC_DIS]   = s_next.dis[i];
                            end else begin
                                rd[PS_CON]   = con_s[i];
                                rd[PS_BIAS]  = bias_s[i];
                                rd[PS_FAULT] = fault_s[i];
                                rd[PS_DIS]   = s_next.dis[i];
                                rd[PS_INTEN] = s_next.int_en[i];
                            end
                        end
                    end
                end
                ADDR_PHY_STAT: begin
                    rd[PH_LINK]  = link_s;
                    rd[PH_CSS]   = css_s;
                    rd[PH_BUSY]  = (s_next.rst != RST_IDLE);
                    rd[PH_SHORT] = (s_next.rst == RST_SHORT);
                end
                default: begin
                    rd = '0;
                end
            endcase
            s_next.rdata = rd;
        end
    end

    // State register; hardware reset clears every control and flag.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg     <= '0;
            s_reg.rst <= RST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs other than hreadyout and hresp come straight from the state register.
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign hrdata          = s_reg.rdata;
    assign bus_reset_drive = (s_reg.rst != RST_IDLE);
    assign bus_reset_short = (s_reg.rst == RST_SHORT);
    assign accel_en        = s_reg.accel;
    assign multi_en        = s_reg.multi;
    assign page_sel        = s_reg.page;
    assign port_sel        = s_reg.port;
    assign port_dis        = s_reg.dis;
    assign link_wake       = s_reg.wake;
    assign irq             = s_reg.irq;

endmodule : pbc_top

`default_nettype wire

// [tb/pbc_link_model.sv]
`timescale 1ns/10ps
`default_nettype none

module pbc_link_model #(
    parameter int WAKE_DLY = 4
) (
    // Clock and reset.
    input  wire logic hclk,
    input  wire logic hresetn,
    // Wake request from the PHY and a sleep command from the bench.
    input  wire logic link_wake,
    input  wire logic go_idle,
    // Activity level seen by the PHY.
    output logic      link_active
);
    int cnt;

    // Sleeps on command and comes back a few cycles after a wake request.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_active <= 1'b1;
            cnt <= 0;
        end else if (go_idle) begin
            link_active <= 1'b0;
            cnt <= 0;
        end else if (!link_active && link_wake) begin
            cnt <= cnt + 1;
            if (cnt == WAKE_DLY - 1) begin
                link_active <= 1'b1;
            end
        end
    end
endmodule : pbc_link_model

`default_nettype wire

// [tb/pbc_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module pbc_properties
    import pbc_pkg::*;
#(
    parameter int LONG_CYC = LONG_RESET_CYC
) (
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Bus request and read data.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic              hready,
    input  wire logic [31:0]       hrdata,
    // Core inputs and link level.
    input  wire logic              arb_opportunity,
    input  wire logic              state_timeout,
    input  wire logic              link_active,
    // Controls driven by the block.
    input  wire logic              bus_reset_drive,
    input  wire logic              bus_reset_short,
    input  wire logic              accel_en,
    input  wire logic              multi_en,
    input  wire logic [PAGE_W-1:0] page_sel,
    input  wire logic [PORT_W-1:0] port_sel,
    input  wire logic              link_wake
);
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    int unsigned rcnt;
    logic        ctl_wr;
    logic        port_rd;

    // Address phases of control writes and port status reads.
    assign ctl_wr  = hsel && hready && htrans[1] && hwrite && haddr[7:0] == ADDR_CTRL;
    assign port_rd = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ADDR_PORT_STAT;

    // Counts the cycles of the bus reset now being driven.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rcnt <= 0;
        end else begin
            rcnt <= bus_reset_drive ? rcnt + 1 : 0;
        end
    end

    a_short_len: assert property ($fell(bus_reset_short) |-> rcnt == SHORT_RESET_CYC)
        else $error("short bus reset has the wrong length");
    a_long_len: assert property ($fell(bus_reset_drive) && !$past(bus_reset_short) |-> rcnt == LONG_CYC)
        else $error("long bus reset has the wrong length");
    a_tmo_long: assert property (state_timeout && !bus_reset_drive |=> bus_reset_drive && !bus_reset_short)
        else $error("state timeout did not start a long reset");
    a_reset_cause: assert property ($rose(bus_reset_drive) |-> $past(arb_opportunity) || $past(state_timeout))
        else $error("bus reset began without a cause");
    a_short_in_drive: assert property (bus_reset_short |-> bus_reset_drive)
        else $error("short flag without a driven reset");
    a_wake_off: assert property (link_active [*5] |-> !link_wake)
        else $error("wake raised while the link is active");
    a_sel_hold: assert property ($changed({accel_en, multi_en, page_sel, port_sel}) |->
        $past(ctl_wr, 2)) else $error("control outputs changed without a write");
    a_port_zero: assert property (port_rd && (port_sel >= NUM_PORTS || page_sel != PORT_PAGE) |->
        ##1 hrdata == 32'h0) else $error("absent port status not zero");
endmodule : pbc_properties

bind pbc_top pbc_properties #(.LONG_CYC(LONG_CYC)) u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .arb_opportunity, .state_timeout,
    .link_active, .bus_reset_drive, .bus_reset_short, .accel_en, .multi_en, .page_sel, .port_sel, .link_wake
);

`default_nettype wire

// [tb/pbc_bench.sv]
`timescale 1ns/10ps
`default_nettype none

module pbc_bench;
    import pbc_pkg::*;

    localparam int LONG_SIM = 20;
    localparam int LIM      = 200;

    // Stimulus, valued from time zero.
    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic                 hwrite = 1'b0;
    logic [1:0]           htrans = 2'h0;
    logic [2:0]           hsize = 3'h2;
    logic [31:0]          haddr = 32'h0;
    logic [31:0]          hwdata = 32'h0;
    logic                 cable_supply_sense = 1'b1;
    logic                 arb_opportunity = 1'b0;
    logic [5:0]           pls = 6'h0;
    logic [NUM_PORTS-1:0] port_con = 2'h0;
    logic [NUM_PORTS-1:0] zero2 = 2'h0;
    // Observed outputs.
    logic                 hreadyout, hresp, link_active, bus_reset_drive, bus_reset_short;
    logic                 accel_en, multi_en, link_wake, irq;
    logic [31:0]          hrdata;
    logic [PAGE_W-1:0]    page_sel;
    logic [PORT_W-1:0]    port_sel;
    logic [NUM_PORTS-1:0] port_dis;
    int                   fails = 0;
    int                   n_checks = 0;

    // Clock of 20 ns.
    always #10 hclk = ~hclk;

    pbc_top #(.LONG_CYC(LONG_SIM)) DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .cable_supply_sense, .link_active, .port_bias(zero2),
        .port_con, .port_fault(zero2), .arb_opportunity, .tree_id_timeout(pls[0]),
        .state_timeout(pls[1]), .bus_reset_seen(pls[2]), .resume_start(pls[5:4]),
        .bus_reset_drive, .bus_reset_short, .accel_en, .multi_en, .page_sel, .port_sel,
        .port_dis, .link_wake, .irq
    );
    pbc_link_model u_link (.hclk, .hresetn, .link_wake, .go_idle(pls[3]), .link_active);

    // Prints the counts and the verdict, then stops.
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic give_up;
        fails++;
        close_out();
    endtask : give_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(posedge hclk);
    endtask : ticks

    task automatic pulse(input int i);
        pls[i] <= 1'b1;
        @(posedge hclk);
        pls[i] <= 1'b0;
    endtask : pulse

    // One single transfer: address phase, then data phase, each held until hready.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < LIM);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < LIM);
        rd = hrdata;
        if (k >= LIM) give_up();
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x, exp);
    endtask : rd_chk

    // Waits for a bus reset and counts its cycles; s tells whether it was short.
    task automatic measure(output logic [31:0] n, output logic s);
        int k;
        k = 0;
        do begin @(posedge hclk); k++; end while (bus_reset_drive !== 1'b1 && k < LIM);
        s = bus_reset_short;
        n = 0;
        while (bus_reset_drive === 1'b1 && k < LIM) begin
            n++;
            @(posedge hclk);
            k++;
        end
        if (k >= LIM) give_up();
    endtask : measure

    task automatic t_reset;
        check({accel_en, multi_en, page_sel, port_sel, port_dis, irq, hresp}, 32'h0);
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_STATUS, 32'h0);
        rd_chk(8'h1c, 32'h0);
        rd_chk(ADDR_PHY_STAT, 32'h3);
    endtask : t_reset

    task automatic t_ctrl;
        wr(ADDR_CTRL, 32'hf7c);
        ticks(2);
        check({accel_en, multi_en, page_sel, port_sel}, 32'h1ff);
        pulse(2);
        ticks(2);
        check({accel_en, multi_en, page_sel, port_sel}, 32'h1ff);
        hresetn <= 1'b0;
        ticks(2);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({accel_en, multi_en, page_sel, port_sel}, 32'h0);
    endtask : t_ctrl

    task automatic t_short;
        logic [31:0] n;
        logic        s;
        wr(ADDR_CTRL, 32'h1);
        pulse(2);
        rd_chk(ADDR_CTRL, 32'h0);
        arb_opportunity <= 1'b1;
        ticks(4);
        check(bus_reset_drive, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        measure(n, s);
        check(n, SHORT_RESET_CYC);
        check(s, 1'b1);
        arb_opportunity <= 1'b0;
        rd_chk(ADDR_CTRL, 32'h0);
    endtask : t_short

    // Each event in turn: flag, interrupt, ignored zero write, clear by one.
    task automatic t_events;
        logic [31:0] n;
        logic        s;
        wr(ADDR_IRQ_EN, 32'hf);
        wr(ADDR_CTRL, 32'h2);
        for (int i = 0; i < 4; i++) begin
            case (i)
                0: pulse(0);
                1: cable_supply_sense <= 1'b0;
                2: pulse(1);
                default: pulse(4);
            endcase
            if (i == 2) begin
                measure(n, s);
                check({s, n[30:0]}, {1'b0, 31'(LONG_SIM)});
            end else begin
                ticks(6);
            end
            rd_chk(ADDR_STATUS, 32'h1 << i);
            check(irq, 1'b1);
            wr(ADDR_CLEAR, 32'h0);
            rd_chk(ADDR_STATUS, 32'h1 << i);
            wr(ADDR_CLEAR, 32'h1 << i);
            rd_chk(ADDR_STATUS, 32'h0);
            check(irq, 1'b0);
            cable_supply_sense <= 1'b1;
            ticks(4);
        end
        wr(ADDR_CTRL, 32'h0);
        pulse(4);
        ticks(6);
        rd_chk(ADDR_STATUS, 32'h0);
    endtask : t_events

    task automatic t_port;
        wr(ADDR_PORT_CTRL, 32'h1);
        port_con[1] <= 1'b1;
        ticks(6);
        rd_chk(ADDR_STATUS, 32'h0);
        port_con[0] <= 1'b1;
        ticks(6);
        rd_chk(ADDR_STATUS, 32'h8);
        check(irq, 1'b1);
        rd_chk(ADDR_PORT_STAT, 32'h11);
        wr(ADDR_CLEAR, 32'h8);
        wr(ADDR_PORT_CTRL, 32'h3);
        ticks(6);
        rd_chk(ADDR_STATUS, 32'h8);
        check(port_dis, 2'h1);
        wr(ADDR_CLEAR, 32'h8);
        wr(ADDR_CTRL, 32'h200);
        wr(ADDR_PORT_CTRL, 32'h3);
        rd_chk(ADDR_PORT_STAT, 32'h0);
        rd_chk(ADDR_PORT_CTRL, 32'h0);
    endtask : t_port

    task automatic t_wake;
        int k;
        wr(ADDR_CTRL, 32'h2);
        pulse(0);
        ticks(1);
        pulse(3);
        k = 0;
        do begin @(posedge hclk); k++; end while (link_wake !== 1'b1 && k < 50);
        check(link_wake, 1'b1);
        do begin @(posedge hclk); k++; end while ((link_active !== 1'b1 || link_wake !== 1'b0) && k < 50);
        check({link_active, link_wake}, 32'h2);
        wr(ADDR_CLEAR, 32'h1);
    endtask : t_wake

    // Main sequence after two cycles of reset.
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_ctrl();
        t_short();
        t_events();
        t_port();
        t_wake();
        close_out();
    end
endmodule : pbc_bench

`default_nettype wire
